// >>> rtl/pmc_ctrl.sv
// Power mode and clock controller: mode sequencer, clock select and gates.
// Assumes oscillator status and supply comparators arrive asynchronously.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps

module pmc_ctrl
  import pmc_pkg::*;
(
  input  wire logic        pclk,         // System clock, 200 MHz
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error, unmapped address
  input  wire logic        wfe_exec,     // Core executes wait for event
  input  wire logic        wfi_exec,     // Core executes wait for interrupt
  input  wire pmc_wake_t   wake_in,      // Wake sources, same domain
  input  wire logic [3:0]  osc_in,       // Raw oscillator clocks, async
  input  wire logic        hsx_fail,     // Fast external osc failure, async
  input  wire logic        vdd_low,      // Below power-on or brownout level, async
  input  wire logic        sld_above,    // Supply above detector level, async
  input  wire logic [2:0]  opt_bor_lvl,  // Option byte brownout level
  input  wire logic        opt_bor_off,  // Option byte brownout disable
  input  wire logic        opt_valid,    // Option bytes loaded
  output pmc_gates_t       gates,        // Clock enables
  output logic             sys_tick,     // Prescaled system clock enable
  output logic             reg_lowpwr,   // Regulator in low power mode
  output logic             ref_on,       // Internal reference enabled
  output logic             bor_on,       // Brownout detector enabled
  output logic [2:0]       bor_lvl,      // Brownout threshold select
  output logic [2:0]       sld_lvl,      // Detector level select
  output logic             sld_irq,      // Detector interrupt, level
  output logic             sys_rst_n,    // System reset, active low
  output logic [1:0]       rtc_src,      // Rtc oscillator select
  output logic [1:0]       lcd_src,      // Display oscillator select
  output logic             clk_out       // Clock out pin
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pmc_state_t  st;        // Mode sequencer
    logic [2:0]  req;       // Requested sleep mode
    logic        fast_wake; // Skip reference settle
    logic        ref_auto;  // Drop reference in halt
    logic [1:0]  src_sel;   // Software source choice
    logic [1:0]  src_act;   // Source actually driving
    logic [2:0]  div;       // Prescaler exponent
    logic        mon_en;    // Failure monitor enable
    logic        mon_hit;   // Failure fell back
    logic [5:0]  gate_sw;   // Software gates: cpu, periph x4, mem
    logic [1:0]  rtc_s;     // Rtc source
    logic [1:0]  lcd_s;     // Display source
    logic [1:0]  co_s;      // Clock out source
    logic        co_en;     // Clock out enable
    logic        sld_en;    // Detector enable
    logic [2:0]  sld_l;     // Detector level
    logic        sld_fall;  // Interrupt on falling
    logic        sld_rise;  // Interrupt on rising
    logic        sld_flag;  // Detector sticky flag
    logic        sld_prev;  // Filtered above, last
    logic [12:0] cnt;       // Wake or switch counter
    logic [6:0]  pre;       // Prescaler counter
    logic [2:0]  s_fail;    // Sync chain, failure
    logic [2:0]  s_vlow;    // Sync chain, supply low
    logic [2:0]  s_above;   // Sync chain, detector
    logic [2:0]  s_co;      // Sync chain, clock out source
    logic        opt_done;  // Options applied
    logic        bor_dis;   // Brownout disabled by option
    logic [2:0]  bor_l;     // Brownout level
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
    pmc_gates_t  g;
    logic        tick;
    logic        co;
    logic        rst_n;
  } pmc_regs_t;

  pmc_regs_t r;       // Registered state
  pmc_regs_t next_r;  // Next state

  logic wr;  // Write access
  logic rd;  // Read access
  logic hit; // Mapped address

  assign wr  = psel & penable & pwrite;
  assign rd  = psel & penable & ~pwrite;
  assign hit = (paddr == PMC_MODE_OFS) | (paddr == PMC_CLK_OFS) | (paddr == PMC_GATE_OFS) |
               (paddr == PMC_SUP_OFS) | (paddr == PMC_STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Single combinational pass; every field starts from its held value so
  // that a branch which does not touch a field leaves it alone.
  // Order matters below: later assignments win over earlier ones, which is
  // how a hardware set beats a software clear in the same cycle.
  always_comb begin
    logic fail_now;   // Filtered failure
    logic vlow_now;   // Filtered supply low
    logic above_now;  // Filtered detector
    logic sleep_cpu;  // Cpu clock stopped
    next_r = r;
    fail_now  = r.s_fail[1] & r.s_fail[2];
    vlow_now  = r.s_vlow[1] & r.s_vlow[2];
    above_now = (r.s_above[1] == r.s_above[2]) ? r.s_above[2] : r.sld_prev;
    // Asynchronous levels pass three flops; stage zero may be metastable,
    // so only stages one and two are ever looked at.
    // The clock out chain only follows the selected oscillator; it is a
    // sampled copy, good for slow sources only at this pclk rate.
    // Three-stage input chains; only stages two and three are compared
    next_r.s_fail  = {r.s_fail[1:0], hsx_fail};
    next_r.s_vlow  = {r.s_vlow[1:0], vdd_low};
    next_r.s_above = {r.s_above[1:0], sld_above};
    next_r.s_co    = {r.s_co[1:0], osc_in[r.co_s]};

    // APB: the answer is prepared in the setup cycle and registered, so
    // pready, prdata and pslverr all stand in the first access cycle.
    // A write lands only at the edge where pready is seen high.
    // APB, zero wait states
    next_r.rdy = psel & ~penable;
    next_r.err = psel & ~penable & ~hit;
    next_r.rdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        PMC_MODE_OFS: next_r.rdata = {27'h0, r.ref_auto, r.fast_wake, r.req};
        PMC_CLK_OFS:  next_r.rdata = {19'h0, r.co_en, r.co_s, r.lcd_s, r.rtc_s, r.mon_en,
                                      r.div, r.src_sel};
        PMC_GATE_OFS: next_r.rdata = {26'h0, r.gate_sw};
        PMC_SUP_OFS:  next_r.rdata = {26'h0, r.sld_rise, r.sld_fall, r.sld_l, r.sld_en};
        PMC_STAT_OFS: next_r.rdata = {19'h0, r.st, r.src_act, r.mon_hit, r.sld_flag,
                                      r.sld_prev};
        default:      next_r.rdata = 32'h0000_0000;
      endcase
    end
    if (wr & r.rdy) begin
      case (paddr)
        PMC_MODE_OFS: begin
          next_r.req       = pwdata[2:0];
          next_r.fast_wake = pwdata[3];
          next_r.ref_auto  = pwdata[4];
        end
        PMC_CLK_OFS: begin
          next_r.src_sel = pwdata[1:0];
          next_r.div     = pwdata[4:2];
          next_r.mon_en  = pwdata[5];
          next_r.rtc_s   = pwdata[7:6];
          next_r.lcd_s   = pwdata[9:8];
          next_r.co_s    = pwdata[11:10];
          next_r.co_en   = pwdata[12];
        end
        PMC_GATE_OFS: next_r.gate_sw = pwdata[5:0];
        PMC_SUP_OFS: begin
          next_r.sld_en   = pwdata[0];
          next_r.sld_l    = (pwdata[3:1] >= PMC_SLD_LVLS) ? 3'h6 : pwdata[3:1];
          next_r.sld_fall = pwdata[4];
          next_r.sld_rise = pwdata[5];
        end
        PMC_STAT_OFS: if (pwdata[1]) next_r.sld_flag = 1'b0; // Write one clears
        default: ;
      endcase
    end

    // Edges are taken on the filtered level; a disabled detector
    // never sets the flag, whatever the supply does.
    // Supply detector edges; set beats the clear above
    next_r.sld_prev = above_now;
    if (r.sld_en & ((r.sld_fall & r.sld_prev & ~above_now) |
                    (r.sld_rise & ~r.sld_prev & above_now)))
      next_r.sld_flag = 1'b1;

    // Option bytes are taken once per reset, after the supply is good; an
    // out of range level is clamped to the highest threshold.
    // Brownout options once the supply is good
    next_r.rst_n = ~vlow_now;
    if (opt_valid & ~r.opt_done & ~vlow_now) begin
      next_r.opt_done = 1'b1;
      next_r.bor_dis  = opt_bor_off;
      next_r.bor_l    = (opt_bor_lvl >= PMC_BOR_LVLS) ? 3'h4 : opt_bor_lvl;
    end

    // Only a running fast external source is watched; a failure seen while
    // another source drives the system changes nothing but is not lost,
    // since the chain keeps showing it until the oscillator recovers.
    // Failure monitor falls back to internal rc
    if (r.mon_en & fail_now & (r.src_act == PMC_OSC_HSX)) begin
      next_r.src_act = PMC_OSC_HRC;
      next_r.src_sel = PMC_OSC_HRC;
      next_r.mon_hit = 1'b1;
    end

    // Sleep requests are taken in run, and wfe also in low power run; the requested mode is the one
    // software left in the mode register before the core slept.
    // Low power run needs a slow source already active, so software first
    // switches the source and then asks for the mode.
    // Halt and active-halt leave through the wake state, which counts the
    // regulator and reference restart before the core clock returns.
    // Mode sequencer
    if (r.cnt != 13'h0000) next_r.cnt = r.cnt - 13'h0001;
    case (r.st)
      PMC_ST_RUN: begin
        if (r.src_sel != r.src_act) begin
          // Hold consumers for a few cycles around the swap
          if (r.cnt == 13'h0000) next_r.cnt = 13'(PMC_SWITCH_CYC);
          if (r.cnt == 13'h0001) next_r.src_act = r.src_sel;
        end else if (wfi_exec | wfe_exec) begin
          case (r.req)
            PMC_REQ_WAIT:  next_r.st = PMC_ST_WAIT;
            PMC_REQ_AHALT: next_r.st = PMC_ST_AHALT;
            PMC_REQ_HALT:  next_r.st = PMC_ST_HALT;
            default:       next_r.st = PMC_ST_WAIT;
          endcase
        end else if (r.req == PMC_REQ_LPRUN && r.src_act[1]) begin
          next_r.st = PMC_ST_LPRUN;
        end
      end
      PMC_ST_WAIT:
        if (wake_in.irq | wake_in.event_in) next_r.st = PMC_ST_RUN;
      PMC_ST_LPRUN: begin
        // Interrupts are ignored here
        if (wfe_exec) next_r.st = PMC_ST_LPWT;
        else if (r.req != PMC_REQ_LPRUN) next_r.st = PMC_ST_RUN;
      end
      PMC_ST_LPWT:
        if (wake_in.event_in) next_r.st = PMC_ST_LPRUN;
      PMC_ST_AHALT:
        if (wake_in.rtc | wake_in.ext_irq) begin
          next_r.st  = PMC_ST_WAKE;
          next_r.cnt = r.fast_wake ? 13'(PMC_FAST_CYC) : 13'(PMC_REF_CYC);
        end
      PMC_ST_HALT:
        if (wake_in.ext_irq | wake_in.periph) begin
          next_r.st  = PMC_ST_WAKE;
          next_r.cnt = (r.fast_wake | ~r.ref_auto) ? 13'(PMC_FAST_CYC)
                                                   : 13'(PMC_REF_CYC);
        end
      PMC_ST_WAKE:
        if (r.cnt == 13'h0001) next_r.st = PMC_ST_RUN;
      default: next_r.st = PMC_ST_RUN;
    endcase

    // Gates follow the state being entered, not the one being left, so the
    // regulator flag and the memory gate change at the same edge.
    // Peripherals run in run, wait and both low power run states; memory
    // only with the main regulator; the rtc clock stops only in halt.
    // Limitation: software gates apply on top of the mode, never against it.
    // Regulator, gates and prescaler
    sleep_cpu = ~((next_r.st == PMC_ST_RUN) | (next_r.st == PMC_ST_LPRUN)) |
                (next_r.cnt != 13'h0000);
    next_r.g.cpu    = r.gate_sw[5] & ~sleep_cpu;
    next_r.g.periph = r.gate_sw[4:1] & {4{(next_r.st == PMC_ST_RUN) |
                      (next_r.st == PMC_ST_WAIT) | (next_r.st == PMC_ST_LPRUN) |
                      (next_r.st == PMC_ST_LPWT)}};
    next_r.g.mem    = r.gate_sw[0] & ((next_r.st == PMC_ST_RUN) |
                      (next_r.st == PMC_ST_WAIT));
    next_r.g.rtc    = next_r.st != PMC_ST_HALT;
    next_r.pre  = (r.pre >= ((7'h01 << r.div) - 7'h01)) ? 7'h00 : r.pre + 7'h01;
    next_r.tick = (r.pre == 7'h00) & (r.cnt == 13'h0000);
    next_r.co   = r.co_en & r.s_co[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register
  // Reset values come from the package; the rest of the struct clears.
  // All outputs but reg_lowpwr, ref_on and bor_on are taken straight from these flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r         <= '0;
      r.st      <= PMC_ST_RUN;
      r.src_sel <= PMC_SRC_RST;
      r.src_act <= PMC_SRC_RST;
      r.div     <= PMC_DIV_RST;
      r.gate_sw <= PMC_GATE_RST[5:0];
      r.rtc_s   <= PMC_OSC_LRC;
      r.lcd_s   <= PMC_OSC_LRC;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulator and reference registered alongside the sequencer
  // They follow the next state so that they switch at the same edge as the
  // sequencer, without a cycle of main regulator in halt.
  // Reference drops only in halt, and only when software asks for it.
  logic reg_lp_q;  // Regulator mode flop
  logic ref_q;     // Reference enable flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_lp_q <= 1'b0;
      ref_q    <= 1'b1;
    end else begin
      reg_lp_q <= (next_r.st == PMC_ST_LPRUN) | (next_r.st == PMC_ST_LPWT) |
                  (next_r.st == PMC_ST_AHALT) | (next_r.st == PMC_ST_HALT);
      ref_q    <= ~((next_r.st == PMC_ST_HALT) & r.ref_auto);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Brownout detection cannot outlive the reference it compares against.
  assign prdata     = r.rdata;
  assign pready     = r.rdy;
  assign pslverr    = r.err;
  assign gates      = r.g;
  assign sys_tick   = r.tick;
  assign reg_lowpwr = reg_lp_q;
  assign ref_on     = ref_q;
  assign bor_on     = ref_q & ~r.bor_dis;
  assign bor_lvl    = r.bor_l;
  assign sld_lvl    = r.sld_l;
  assign sld_irq    = r.sld_flag;
  assign sys_rst_n  = r.rst_n;
  assign rtc_src    = r.rtc_s;
  assign lcd_src    = r.lcd_s;
  assign clk_out    = r.co;

endmodule : pmc_ctrl

// >>> rtl/pmc_pkg.sv
// Package for the power mode and clock controller: register map, fields, states, timing.
// Assumes a 200 MHz pclk and a 32-bit APB master.
package pmc_pkg;

  // Register byte offsets
  localparam logic [11:0] PMC_MODE_OFS  = 12'h000;  // Mode request and wake config
  localparam logic [11:0] PMC_CLK_OFS   = 12'h004;  // Clock source, prescaler, monitor
  localparam logic [11:0] PMC_GATE_OFS  = 12'h008;  // Clock gate enables
  localparam logic [11:0] PMC_SUP_OFS   = 12'h00C;  // Supply detector setup
  localparam logic [11:0] PMC_STAT_OFS  = 12'h010;  // Status; writing one to bit 1 clears the detector flag

  // Mode request codes
  localparam logic [2:0] PMC_REQ_RUN   = 3'h0;
  localparam logic [2:0] PMC_REQ_WAIT  = 3'h1;
  localparam logic [2:0] PMC_REQ_LPRUN = 3'h2;
  localparam logic [2:0] PMC_REQ_AHALT = 3'h3;
  localparam logic [2:0] PMC_REQ_HALT  = 3'h4;

  // Oscillator codes
  localparam logic [1:0] PMC_OSC_HSX = 2'h0;  // fast_external_osc
  localparam logic [1:0] PMC_OSC_HRC = 2'h1;  // fast_internal_rc
  localparam logic [1:0] PMC_OSC_LSX = 2'h2;  // slow_external_crystal
  localparam logic [1:0] PMC_OSC_LRC = 2'h3;  // slow_internal_rc

  // Reset values and level counts
  localparam logic [1:0] PMC_SRC_RST  = PMC_OSC_HRC;  // Internal RC after reset
  localparam logic [2:0] PMC_DIV_RST  = 3'h3;         // Divide by 2**3 = 8
  localparam logic [7:0] PMC_GATE_RST = 8'hFF;        // All gates open
  localparam logic [2:0] PMC_BOR_LVLS = 3'h5;         // Brownout thresholds
  localparam logic [2:0] PMC_SLD_LVLS = 3'h7;         // Supply detector levels

  // Timing
  localparam int PMC_CLK_MHZ      = 200;
  localparam int PMC_FAST_WAKE_US = 5;   // Fast wakeup from halt
  localparam int PMC_REF_WAKE_US  = 20;  // Reference settle, plain default
  localparam int PMC_FAST_CYC = PMC_FAST_WAKE_US * PMC_CLK_MHZ;
  localparam int PMC_REF_CYC  = PMC_REF_WAKE_US * PMC_CLK_MHZ;
  localparam int PMC_SWITCH_CYC = 4;     // Dead cycles in a source change

  typedef enum logic [6:0] {
    PMC_ST_RUN   = 7'b000_0001,
    PMC_ST_WAIT  = 7'b000_0010,
    PMC_ST_LPRUN = 7'b000_0100,
    PMC_ST_LPWT  = 7'b000_1000,
    PMC_ST_AHALT = 7'b001_0000,
    PMC_ST_HALT  = 7'b010_0000,
    PMC_ST_WAKE  = 7'b100_0000
  } pmc_state_t;

  // Wake sources from the rest of the chip
  typedef struct packed {
    logic irq;      // Any internal or external interrupt
    logic ext_irq;  // External interrupt line
    logic event_in; // Event from timers, serial, transfer ctl, ports
    logic rtc;      // Real-time clock interrupt
    logic periph;   // Peripheral wakeup from halt
  } pmc_wake_t;

  // Clock enables towards consumers
  typedef struct packed {
    logic       cpu;      // Processor clock enable
    logic [3:0] periph;   // Peripheral clock enables
    logic       mem;      // Flash and EEPROM clock enable
    logic       rtc;      // Real-time clock enable
  } pmc_gates_t;

endpackage : pmc_pkg

// >>> dv/pmc_ctrl_props.sv
// Checker on the ports of the power mode and clock controller.
// Bound into pmc_ctrl; it needs only that module's top-level ports.
`timescale 1ns/10ps
module pmc_ctrl_props
  import pmc_pkg::*;
(
  input wire logic       pclk,       // Clock
  input wire logic       presetn,    // Reset, low
  input wire logic       psel,       // APB select
  input wire logic       penable,    // APB access
  input wire logic       pready,     // APB ready
  input wire logic       pslverr,    // APB error
  input wire logic       vdd_low,    // Supply low
  input wire logic       sys_rst_n,  // System reset
  input wire logic       reg_lowpwr, // Regulator low
  input wire logic       ref_on,     // Reference on
  input wire logic       bor_on,     // Brownout on
  input wire logic [2:0] bor_lvl,    // Brownout level
  input wire pmc_gates_t gates       // Clock enables
);
  ////////////////////////////////////////////////////////////////////////////
  // One domain; reset silences every check
  default clocking pmc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus answers in the first access cycle, for one cycle only
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // Synchroniser gives some slack, but a long low supply must hold reset
  rst_hold_a: assert property (vdd_low [*8] |-> !sys_rst_n)
    else $error("reset released on low supply");
  bor_range_a: assert property (bor_lvl < PMC_BOR_LVLS)
    else $error("brownout level out of range");
  ref_bor_a: assert property (!ref_on |-> !bor_on)
    else $error("brownout on without reference");
  lp_mem_a: assert property (reg_lowpwr |-> !gates.mem)
    else $error("memory clocked on low regulator");

  // Main scenarios reached
  cover property (pslverr);
  cover property (reg_lowpwr && gates.cpu);
  cover property (reg_lowpwr && !gates.cpu);
endmodule : pmc_ctrl_props

bind pmc_ctrl pmc_ctrl_props i_pmc_ctrl_props (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .vdd_low, .sys_rst_n, .reg_lowpwr, .ref_on, .bor_on, .bor_lvl, .gates);

// >>> dv/pmc_core_model.sv
// Core and oscillator model beside the power mode controller.
// The bench asks it for sleep instructions; oscillators run free.
`timescale 1ns/10ps
module pmc_core_model
  import pmc_pkg::*;
(
  input  wire logic       pclk,      // System clock
  input  wire logic [1:0] sleep_req, // 1 wfi, 2 wfe
  input  wire pmc_gates_t gates,     // Clock enables
  input  wire logic       sys_tick,  // Prescaled enable
  output logic            wfi_exec,  // Wfi executed
  output logic            wfe_exec,  // Wfe executed
  output logic [3:0]      osc_in,    // Oscillators
  output int              cpu_ticks  // Core ticks seen
);
  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillators sped up so that source switches stay short
  initial begin
    osc_in = 4'h0;
    wfi_exec = 1'h0;
    wfe_exec = 1'h0;
    cpu_ticks = 0;
  end
  always #31.25 osc_in[0] = ~osc_in[0]; // Fast external
  always #31.0 osc_in[1] = ~osc_in[1];  // Fast internal rc
  always #150.0 osc_in[2] = ~osc_in[2]; // Slow crystal
  always #130.0 osc_in[3] = ~osc_in[3]; // Slow rc

  // Sleeps come only from software, and only while the core is clocked
  always @(posedge pclk) begin
    wfi_exec <= sleep_req == 2'h1 && gates.cpu;
    wfe_exec <= sleep_req == 2'h2 && gates.cpu;
    if (gates.cpu && sys_tick)
      cpu_ticks <= cpu_ticks + 1;
  end
endmodule : pmc_core_model

// >>> dv/tb_pmc_ctrl.sv
// Self-checking bench for the power mode and clock controller.
// Needs the core model and the bound checker compiled with it.
`timescale 1ns/10ps
module tb_pmc_ctrl
  import pmc_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] wd, msk, exp; logic err;} pmc_row_t;
  typedef struct {logic [31:0] md; pmc_wake_t wk; int cyc;} pmc_nap_t;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        hsx_fail = 1'h0, vdd_low = 1'h0, sld_above = 1'h0; // Faults, supply
  logic        opt_bor_off = 1'h0, opt_valid = 1'h1;              // Option bytes
  logic [2:0]  opt_bor_lvl = 3'h2;                                // Option level
  logic [11:0] paddr = 12'h000;                                   // Address
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;                // Data
  logic [1:0]  sleep_req = 2'h0, rtc_src, lcd_src;                // Sleep, selects
  pmc_wake_t   wake_in = '0;                                      // Wake sources
  logic        pready, pslverr, er, wfe_exec, wfi_exec, sys_tick, reg_lowpwr;
  logic        ref_on, bor_on, sld_irq, sys_rst_n, clk_out;       // Status
  logic [3:0]  osc_in;                                            // Oscillators
  logic [2:0]  bor_lvl, sld_lvl;                                  // Levels
  pmc_gates_t  gates;                                             // Enables
  int          cpu_ticks, err_total = 0, checks = 0, n, k, t;     // Counters
  pmc_row_t    rows [6];
  pmc_nap_t    naps [3];
  pmc_ctrl       i_pmc_ctrl (.*);
  pmc_core_model i_pmc_core_model (.*);
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks: compare, bus cycle, bounded wait, pulses, tick count
  task automatic chk(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (k == 50) begin
      chk("apb wait", 0, 1);
      test_done();
    end
    @(posedge pclk);
  endtask : apb
  task automatic ws(input int s, input logic v);
    for (n = 0; n < 6000 && (s == 0 ? gates.cpu : s == 1 ? reg_lowpwr
         : s == 2 ? sys_rst_n : sld_irq) !== v; n++) @(posedge pclk);
    if (n == 6000) begin
      chk("wait", 0, 1);
      test_done();
    end
  endtask : ws
  task automatic sl(input logic [1:0] r, input pmc_wake_t w);
    sleep_req <= r;
    wake_in <= w;
    @(posedge pclk);
    sleep_req <= 2'h0;
    wake_in <= '0;
  endtask : sl
  task automatic tk(input int e);
    t = 0;
    repeat (80) begin
      @(posedge pclk);
      t += int'(sys_tick === 1'h1);
    end
    chk("ticks", e, t);
  endtask : tk
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{12'h004, 32'h0000_1C89, 32'h0000_1FFF, 32'h0000_1C89, 1'h0},
             '{12'h008, 32'h0000_002A, 32'h0000_003F, 32'h0000_002A, 1'h0},
             '{12'h00C, 32'h0000_003D, 32'h0000_003F, 32'h0000_003D, 1'h0},
             '{12'h000, 32'h0000_0018, 32'h0000_001F, 32'h0000_0018, 1'h0},
             '{12'h014, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1},
             '{12'hFFC, 32'h0000_1234, 32'hFFFF_FFFF, 32'h0000_0000, 1'h1}};
    naps = '{'{32'h0000_000C, 5'h08, PMC_FAST_CYC}, '{32'h0000_0014, 5'h01, PMC_REF_CYC},
             '{32'h0000_000B, 5'h02, PMC_FAST_CYC}};
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, PMC_CLK_OFS, 32'h0);
    chk("clk rst", 32'h0000_000D, rd & 32'h0000_001F);
    apb(1'h0, PMC_STAT_OFS, 32'h0);
    chk("stat rst", 32'h0000_0028, rd & 32'h0000_0FFC);
    chk("supv rst", 32'h0000_0032, {26'h0, ref_on, bor_on, 1'h0, bor_lvl});
    tk(10);
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].wd);
      chk("wr err", rows[i].err, er);
      apb(1'h0, rows[i].a, 32'h0);
      chk("rd back", rows[i].exp, rd & rows[i].msk);
      chk("rd err", rows[i].err, er);
    end
    chk("side src", 32'h0000_0008, {28'h0, rtc_src, lcd_src});
    chk("gates", 32'h0000_002A, {26'h0, gates.cpu, gates.periph, gates.mem});
    tk(20);
    apb(1'h1, PMC_GATE_OFS, 32'h0000_003F);
    apb(1'h1, PMC_MODE_OFS, 32'h0000_0001);
    // Wait: core stops while peripherals keep their clocks
    sl(2'h1, '0);
    ws(0, 1'h0);
    t = cpu_ticks;
    repeat (20) @(posedge pclk);
    chk("wait core", t, cpu_ticks);
    chk("wait per", 32'h0000_001E, {27'h0, gates.periph, reg_lowpwr});
    sl(2'h0, 5'h10);
    ws(0, 1'h1);
    // Low power run on the slow rc; interrupts must not end it
    apb(1'h1, PMC_CLK_OFS, 32'h0000_000F);
    repeat (300) @(posedge pclk);
    apb(1'h1, PMC_MODE_OFS, 32'h0000_0002);
    ws(1, 1'h1);
    chk("lprun gate", 32'h0000_0002, {30'h0, gates.cpu, gates.mem});
    sl(2'h0, 5'h18);
    repeat (10) @(posedge pclk);
    chk("lprun kept", 1, reg_lowpwr);
    sl(2'h2, '0);
    ws(0, 1'h0);
    chk("lpwait reg", 1, reg_lowpwr);
    sl(2'h0, 5'h04);
    ws(0, 1'h1);
    chk("lpwait back", 1, reg_lowpwr);
    apb(1'h1, PMC_MODE_OFS, 32'h0000_0000);
    ws(1, 1'h0);
    apb(1'h1, PMC_CLK_OFS, 32'h0000_000D);
    repeat (300) @(posedge pclk);
    // Halt and active-halt, fast and reference-settled wakeups
    foreach (naps[i]) begin
      apb(1'h1, PMC_MODE_OFS, naps[i].md);
      sl(2'h1, '0);
      ws(0, 1'h0);
      repeat (8) @(posedge pclk);
      chk("nap reg", 1, reg_lowpwr);
      chk("nap per", 0, gates.periph);
      chk("nap ref", {2{~naps[i].md[4]}}, {ref_on, bor_on});
      if (naps[i].md[2:0] == 3'h3)
        chk("nap rtc", 1, gates.rtc);
      sl(2'h0, naps[i].wk);
      ws(0, 1'h1);
      chk("nap time", 1, n + 2 >= naps[i].cyc && n <= naps[i].cyc + 16);
      chk("wake reg", 0, reg_lowpwr);
    end
    apb(1'h1, PMC_MODE_OFS, 32'h0000_0000);
    // Monitor falls back to the internal rc on external failure
    apb(1'h1, PMC_CLK_OFS, 32'h0000_002C);
    repeat (300) @(posedge pclk);
    hsx_fail <= 1'h1;
    repeat (60) @(posedge pclk);
    apb(1'h0, PMC_STAT_OFS, 32'h0);
    chk("fallback", 32'h0000_000C, rd & 32'h0000_001C);
    hsx_fail <= 1'h0;
    // Supply detector: rise, clear, fall
    sld_above <= 1'h1;
    ws(3, 1'h1);
    apb(1'h1, PMC_STAT_OFS, 32'h0000_0002);
    @(posedge pclk);
    chk("flag clr", 0, sld_irq);
    sld_above <= 1'h0;
    ws(3, 1'h1);
    vdd_low <= 1'h1;
    ws(2, 1'h0);
    vdd_low <= 1'h0;
    ws(2, 1'h1);
    // Reset in mid-run brings back the default source and prescaler
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, PMC_CLK_OFS, 32'h0);
    chk("clk rerst", 32'h0000_000D, rd & 32'h0000_001F);
    test_done();
  end
endmodule : tb_pmc_ctrl
